// >>> hdl/feed_sequencer.sv
/*
 * feed_sequencer: tracks the two-byte feed pair and flags any watchdog
 * register access that breaks an open pair.
 * assumes acc is high for exactly one cycle per bus access.
 */
`timescale 1ns/1ps
module feed_sequencer
    import wdt_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       clear,
    // observed access
    input  wire logic       acc,
    input  wire logic       mapped,
    input  wire logic       feed_wr,
    input  wire logic [7:0] wbyte,
    // events
    output logic            feed_done,
    output logic            feed_err
);
    typedef enum logic [0:0] {FEED_IDLE, FEED_ARMED} feed_state_t;
    feed_state_t state_r;

    logic second_ok;

    assign second_ok = feed_wr && (wbyte == FEED_KEY_SECOND);
    assign feed_done = (state_r == FEED_ARMED) && acc && second_ok;
    assign feed_err  = (state_r == FEED_ARMED) && acc && mapped && !second_ok;

    always_ff @(posedge mclk) begin
        if (reset || clear) begin
            state_r <= FEED_IDLE;
        end else if (acc && mapped) begin
            unique case (state_r)
                FEED_IDLE:  state_r <= (feed_wr && wbyte == FEED_KEY_FIRST) ? FEED_ARMED : FEED_IDLE;
                FEED_ARMED: state_r <= FEED_IDLE;
            endcase
        end
    end
endmodule // feed_sequencer

// >>> hdl/tick_divider.sv
/*
 * tick_divider: fixed prescaler turning counting-clock enables into
 * counter decrement pulses, one per PRESCALE_DIV enables.
 * assumes tick_en is a one-cycle pulse synchronous to mclk.
 */
`timescale 1ns/1ps
module tick_divider #(
    parameter int DIV = 4
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // control
    input  wire logic restart,
    input  wire logic run,
    input  wire logic tick_en,
    // output
    output logic      dec_en
);
    localparam int PHASE_W = $clog2(DIV);

    logic [PHASE_W-1:0] phase_r;

    assign dec_en = run && tick_en && (phase_r == PHASE_W'(DIV - 1));

    always_ff @(posedge mclk) begin
        if (reset || restart || !run) begin
            phase_r <= '0;
        end else if (tick_en) begin
            phase_r <= dec_en ? '0 : phase_r + 1'b1;
        end
    end
endmodule // tick_divider

// >>> hdl/wdt_pkg.sv
/*
 * wdt_pkg: register map, field positions, reset values, feed keys and
 * the bus request carrier for the windowed watchdog.
 * assumes a single clock domain; the counting clock arrives as an enable.
 */
package wdt_pkg;

    localparam int ADDR_W     = 12;
    localparam int DATA_W     = 32;
    localparam int COUNT_W    = 24;
    localparam int WARN_W     = 10;
    localparam int PRESCALE_DIV = 4;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_MODE     = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_RELOAD   = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_FEED     = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_COUNT    = 12'h00c;
    localparam logic [ADDR_W-1:0] OFF_WARN     = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_WINDOW   = 12'h018;

    // mode_control_status fields
    localparam int BIT_RUN_ENABLE  = 0;
    localparam int BIT_RESET_ON_TO = 1;
    localparam int BIT_TIMEOUT     = 2;
    localparam int BIT_WARNING     = 3;
    localparam int BIT_GUARD       = 4;

    // reset values and reload floor
    localparam logic [COUNT_W-1:0] RELOAD_RST = 24'h0000ff;
    localparam logic [COUNT_W-1:0] COUNT_RST  = 24'h0000ff;
    localparam logic [COUNT_W-1:0] RELOAD_MIN = 24'h0000ff;
    localparam logic [WARN_W-1:0]  WARN_RST   = 10'h000;
    localparam logic [COUNT_W-1:0] WINDOW_RST = 24'hffffff;

    // feed sequence keys
    localparam logic [7:0] FEED_KEY_FIRST  = 8'haa;
    localparam logic [7:0] FEED_KEY_SECOND = 8'h55;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

endpackage

// >>> hdl/windowed_watchdog_timer.sv
/*
 * windowed_watchdog_timer: windowed watchdog with set-only mode bits,
 * feed pair, guarded reload, warning compare and window limit.
 * assumes an apb-style register port on mclk, zero wait states, and a
 * counting-clock enable pulse synchronous to mclk.
 */
`timescale 1ns/1ps
module windowed_watchdog_timer (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset,
    // register port
    input  wire wdt_pkg::apb_req_t     bus,
    output logic [wdt_pkg::DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    // counting clock and power state
    input  wire logic                  count_tick,
    input  wire logic                  sleeping,
    // system outputs
    output logic                       chip_reset_req,
    output logic                       irq,
    output logic                       wake_req,
    output logic                       clk_src_lock
);
    import wdt_pkg::*;

    logic               run_pend_r;
    logic               rst_pend_r;
    logic               guard_pend_r;
    logic               run_en_r;
    logic               rst_en_r;
    logic               guard_r;
    logic               timeout_flag_r;
    logic               warn_flag_r;
    logic [COUNT_W-1:0] reload_r;
    logic [WARN_W-1:0]  warn_cmp_r;
    logic [COUNT_W-1:0] window_r;
    logic [COUNT_W-1:0] count_r;
    logic [COUNT_W-1:0] count_rb_r;
    logic               wd_reset_r;

    logic               setup;
    logic               acc;
    logic               wr;
    logic               mapped;
    logic               sel_mode;
    logic               sel_reload;
    logic               sel_feed;
    logic               sel_count;
    logic               sel_warn;
    logic               sel_window;
    logic               feed_done;
    logic               feed_err;
    logic               dec_en;
    logic               zero_hit;
    logic               warn_hit;
    logic               early_feed;
    logic               guard_wr;
    logic               reload_open;
    logic               tmo_evt;
    logic               tmo_reset;
    logic [COUNT_W-1:0] wdata_cnt;

    // bus decode
    assign setup      = bus.psel && !bus.penable;
    assign acc        = bus.psel && bus.penable;
    assign wr         = acc && bus.pwrite;
    assign sel_mode   = (bus.paddr == OFF_MODE);
    assign sel_reload = (bus.paddr == OFF_RELOAD);
    assign sel_feed   = (bus.paddr == OFF_FEED);
    assign sel_count  = (bus.paddr == OFF_COUNT);
    assign sel_warn   = (bus.paddr == OFF_WARN);
    assign sel_window = (bus.paddr == OFF_WINDOW);
    assign mapped     = sel_mode || sel_reload || sel_feed || sel_count || sel_warn || sel_window;
    assign pready     = 1'b1;
    assign pslverr    = acc && !mapped;
    assign wdata_cnt  = bus.pwdata[COUNT_W-1:0];

    feed_sequencer u_feed (
        .mclk      (mclk),
        .reset     (reset),
        .clear     (wd_reset_r),
        .acc       (acc),
        .mapped    (mapped),
        .feed_wr   (bus.pwrite && sel_feed),
        .wbyte     (bus.pwdata[7:0]),
        .feed_done (feed_done),
        .feed_err  (feed_err)
    );

    tick_divider #(
        .DIV (PRESCALE_DIV)
    ) u_div (
        .mclk    (mclk),
        .reset   (reset),
        .restart (feed_done || wd_reset_r),
        .run     (run_en_r),
        .tick_en (count_tick),
        .dec_en  (dec_en)
    );

    // events
    assign zero_hit    = run_en_r && dec_en && (count_r == '0);
    assign warn_hit    = run_en_r && dec_en && (count_r[COUNT_W-1:WARN_W] == '0)
                         && (count_r[WARN_W-1:0] == warn_cmp_r);
    assign early_feed  = run_en_r && rst_en_r && feed_done && (count_r > window_r);
    assign guard_wr    = wr && sel_reload && guard_r;
    assign reload_open = !guard_r || ((count_r < {14'h0000, warn_cmp_r}) && (count_r < window_r));
    assign tmo_evt     = zero_hit || early_feed || guard_wr || (run_en_r && feed_err);
    assign tmo_reset   = tmo_evt && run_en_r && rst_en_r;

    // set-only mode bits as written
    always_ff @(posedge mclk) begin
        if (reset || wd_reset_r) begin
            run_pend_r   <= 1'b0;
            rst_pend_r   <= 1'b0;
            guard_pend_r <= 1'b0;
        end else if (wr && sel_mode) begin
            run_pend_r   <= run_pend_r   || bus.pwdata[BIT_RUN_ENABLE];
            rst_pend_r   <= rst_pend_r   || bus.pwdata[BIT_RESET_ON_TO];
            guard_pend_r <= guard_pend_r || bus.pwdata[BIT_GUARD];
        end
    end

    // effective mode, taken over only by a completed feed
    always_ff @(posedge mclk) begin
        if (reset || wd_reset_r) begin
            run_en_r <= 1'b0;
            rst_en_r <= 1'b0;
            guard_r  <= 1'b0;
        end else if (feed_done) begin
            run_en_r <= run_pend_r;
            rst_en_r <= rst_pend_r;
            guard_r  <= guard_pend_r;
        end
    end

    assign clk_src_lock = run_pend_r || run_en_r;

    // timeout flag survives a watchdog reset; set beats clear
    always_ff @(posedge mclk) begin
        if (reset) begin
            timeout_flag_r <= 1'b0;
        end else if (tmo_evt) begin
            timeout_flag_r <= 1'b1;
        end else if (wr && sel_mode && !bus.pwdata[BIT_TIMEOUT]) begin
            timeout_flag_r <= 1'b0;
        end
    end

    // warning flag; set beats clear
    always_ff @(posedge mclk) begin
        if (reset || wd_reset_r) begin
            warn_flag_r <= 1'b0;
        end else if (warn_hit) begin
            warn_flag_r <= 1'b1;
        end else if (wr && sel_mode && bus.pwdata[BIT_WARNING]) begin
            warn_flag_r <= 1'b0;
        end
    end

    assign irq      = warn_flag_r && run_en_r;
    assign wake_req = irq && sleeping;

    // configuration registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            reload_r <= RELOAD_RST;
        end else if (wr && sel_reload && reload_open) begin
            reload_r <= (wdata_cnt < RELOAD_MIN) ? RELOAD_MIN : wdata_cnt;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            warn_cmp_r <= WARN_RST;
            window_r   <= WINDOW_RST;
        end else if (wr && sel_warn) begin
            warn_cmp_r <= bus.pwdata[WARN_W-1:0];
        end else if (wr && sel_window) begin
            window_r   <= wdata_cnt;
        end
    end

    // counter
    always_ff @(posedge mclk) begin
        if (reset || wd_reset_r) begin
            count_r <= COUNT_RST;
        end else if (feed_done) begin
            count_r <= reload_r;
        end else if (run_en_r && dec_en) begin
            count_r <= (count_r == '0) ? reload_r : count_r - 1'b1;
        end
    end

    // readback snapshot, so a read never sees a half-updated count
    always_ff @(posedge mclk) begin
        if (reset) begin
            count_rb_r <= COUNT_RST;
        end else begin
            count_rb_r <= count_r;
        end
    end

    // watchdog reset pulse, one cycle after the event
    always_ff @(posedge mclk) begin
        if (reset) begin
            wd_reset_r <= 1'b0;
        end else begin
            wd_reset_r <= tmo_reset;
        end
    end

    assign chip_reset_req = wd_reset_r;

    // read data, captured in the setup phase
    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata <= '0;
        end else if (setup) begin
            prdata <= '0;
            if (sel_mode) begin
                prdata[BIT_RUN_ENABLE]  <= run_en_r;
                prdata[BIT_RESET_ON_TO] <= rst_en_r;
                prdata[BIT_TIMEOUT]     <= timeout_flag_r;
                prdata[BIT_WARNING]     <= warn_flag_r;
                prdata[BIT_GUARD]       <= guard_r;
            end else if (sel_reload) begin
                prdata[COUNT_W-1:0] <= reload_r;
            end else if (sel_count) begin
                prdata[COUNT_W-1:0] <= count_rb_r;
            end else if (sel_warn) begin
                prdata[WARN_W-1:0] <= warn_cmp_r;
            end else if (sel_window) begin
                prdata[COUNT_W-1:0] <= window_r;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_run_set_only: assert property (run_pend_r && !wd_reset_r |=> run_pend_r)
        else $error("run enable cleared without a reset");
    a_clock_lock: assert property (clk_src_lock && !wd_reset_r |=> clk_src_lock)
        else $error("clock source not locked while enabled");
    a_stopped_quiet: assert property (!run_en_r |=> !wd_reset_r && !irq)
        else $error("stopped watchdog raised reset or interrupt");
    a_feed_reload: assert property (feed_done && !wd_reset_r |=> count_r == $past(reload_r))
        else $error("feed did not reload the counter");
    a_mode_on_feed: assert property ($changed(rst_en_r) |-> $past(feed_done) || $past(wd_reset_r))
        else $error("mode changed without a feed");
    a_tof_sticky: assert property (timeout_flag_r && !(wr && sel_mode && !bus.pwdata[BIT_TIMEOUT])
                                   |=> timeout_flag_r)
        else $error("timeout flag lost without a clearing write");
    a_guard_flag: assert property (guard_wr |=> timeout_flag_r)
        else $error("guarded reload write did not set timeout flag");
    a_zero_reset: assert property (zero_hit && rst_en_r |=> chip_reset_req ##1 !chip_reset_req)
        else $error("no single reset pulse at zero");
    a_early_reset: assert property (early_feed |=> chip_reset_req && timeout_flag_r)
        else $error("early feed did not reset");
    a_warn_match: assert property (warn_hit && !wd_reset_r |=> warn_flag_r && irq)
        else $error("warning match did not raise interrupt");
    a_intr_no_reset: assert property (run_en_r && !rst_en_r |=> !chip_reset_req)
        else $error("interrupt mode issued a reset");
    a_wake_sleep: assert property ($rose(warn_flag_r) && sleeping |-> wake_req)
        else $error("interrupt in sleep did not wake");

    // assertion helper: counting ticks seen since the last decrement
    logic [2:0] tick_seen_r;

    always_ff @(posedge mclk) begin
        if (reset || wd_reset_r || feed_done || !run_en_r || dec_en) begin
            tick_seen_r <= 3'h0;
        end else if (count_tick) begin
            tick_seen_r <= tick_seen_r + 3'h1;
        end
    end

    // counting
    a_prescale_four: assert property (dec_en |-> tick_seen_r == 3'(PRESCALE_DIV - 1))
        else $error("decrement not on the fourth counting tick");
    a_count_step: assert property (dec_en && count_r != '0 && !feed_done && !wd_reset_r
                                   |=> count_r == $past(count_r) - 1'b1)
        else $error("counter did not step down by one");
    a_count_hold: assert property (!dec_en && !feed_done && !wd_reset_r |=> $stable(count_r))
        else $error("counter moved while not counting");
    a_tick_stop: assert property (!run_en_r |-> !dec_en)
        else $error("decrement while stopped");
    a_count_wrap: assert property (zero_hit && !rst_en_r && !wd_reset_r |=> count_r == $past(reload_r))
        else $error("interrupt mode did not reload at zero");

    // flags and events
    a_zero_flag: assert property (zero_hit |=> timeout_flag_r)
        else $error("counter timeout did not set timeout flag");
    a_feed_err_flag: assert property (feed_err && run_en_r |=> timeout_flag_r)
        else $error("broken feed pair did not set timeout flag");
    a_feed_err_reset: assert property (feed_err && run_en_r && rst_en_r |=> chip_reset_req)
        else $error("broken feed pair did not reset");
    a_guard_reset: assert property (guard_wr && run_en_r && rst_en_r |=> chip_reset_req)
        else $error("guarded reload write did not reset");
    a_tof_clear: assert property (wr && sel_mode && !bus.pwdata[BIT_TIMEOUT] && !tmo_evt
                                  |=> !timeout_flag_r)
        else $error("writing zero did not clear timeout flag");
    a_warn_clear: assert property (wr && sel_mode && bus.pwdata[BIT_WARNING] && !warn_hit
                                   |=> !warn_flag_r)
        else $error("writing one did not clear warning flag");

    // mode bits and reload
    a_rst_set_only: assert property (rst_pend_r && !wd_reset_r |=> rst_pend_r)
        else $error("reset enable cleared without a reset");
    a_guard_set_only: assert property (guard_pend_r && !wd_reset_r |=> guard_pend_r)
        else $error("reload guard cleared without a reset");
    a_mode_hold: assert property (!feed_done && !wd_reset_r |=> $stable(run_en_r) && $stable(guard_r))
        else $error("mode took effect without a feed");
    a_guard_refuse: assert property (wr && sel_reload && !reload_open
                                     |=> reload_r == $past(reload_r))
        else $error("guarded reload value changed");
    a_reload_floor: assert property (reload_r >= RELOAD_MIN)
        else $error("reload constant below minimum");
endmodule // windowed_watchdog_timer

// >>> tb/cpu_model.sv
/*
 * cpu_model: processor-side master of the watchdog register port.
 * assumes the bench calls its tasks; requests change on the falling
 * edge and are held until pready is sampled high on a rising edge.
 */
`timescale 1ns/1ps
module cpu_model (
    // clock
    input  wire logic                  mclk,
    // register port
    output wdt_pkg::apb_req_t          bus,
    input  wire logic [wdt_pkg::DATA_W-1:0] prdata,
    input  wire logic                  pready,
    input  wire logic                  pslverr
);
    import wdt_pkg::*;

    initial bus = '0;

    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q, output logic err);
        @(negedge mclk);
        bus <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(negedge mclk);
        bus.penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        @(negedge mclk);
        // idle bus carries inverted leftovers, never stale values
        bus <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] q;
        logic              e;
        xfer(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q, output logic e);
        xfer(1'b0, a, '0, q, e);
    endtask

    // key pair; also commits pending mode bits
    task automatic feed();
        wr(OFF_FEED, {24'h000000, FEED_KEY_FIRST});
        wr(OFF_FEED, {24'h000000, FEED_KEY_SECOND});
    endtask
endmodule // cpu_model

// >>> tb/tb.sv
/*
 * tb: self-checking bench for windowed_watchdog_timer.
 * assumes cpu_model drives the register port; ticks, sleep and reset
 * are driven here on the falling edge of mclk.
 */
`timescale 1ns/1ps
module tb;
    import wdt_pkg::*;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] x;
        logic              err;
    } row_t;

    localparam row_t ROWS [10] = '{
        '{1'b0, OFF_MODE,   32'h0,    32'h0,        1'b0},
        '{1'b0, OFF_RELOAD, 32'h0,    32'h000000ff, 1'b0},
        '{1'b0, OFF_FEED,   32'h0,    32'h0,        1'b0},
        '{1'b0, OFF_COUNT,  32'h0,    32'h000000ff, 1'b0},
        '{1'b0, OFF_WARN,   32'h0,    32'h0,        1'b0},
        '{1'b0, OFF_WINDOW, 32'h0,    32'h00ffffff, 1'b0},
        '{1'b1, OFF_RELOAD, 32'h10,   32'h000000ff, 1'b0},
        '{1'b1, OFF_COUNT,  32'h1234, 32'h000000ff, 1'b0},
        '{1'b1, OFF_WARN,   32'h10,   32'h00000010, 1'b0},
        '{1'b0, 12'h010,    32'h0,    32'h0,        1'b1}
    };

    logic              mclk;
    logic              reset;
    logic              count_tick;
    logic              sleeping;
    apb_req_t          bus;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              chip_reset_req;
    logic              irq;
    logic              wake_req;
    logic              clk_src_lock;
    int                num_errors;
    int                total_checks;
    int                n_rst;
    int                n0;
    logic [31:0]       q;
    logic              e;

    windowed_watchdog_timer dut (
        .mclk(mclk), .reset(reset), .bus(bus), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_tick(count_tick), .sleeping(sleeping), .chip_reset_req(chip_reset_req), .irq(irq),
        .wake_req(wake_req), .clk_src_lock(clk_src_lock)
    );

    cpu_model cpu (.mclk(mclk), .bus(bus), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (chip_reset_req === 1'b1) n_rst++;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic test_end(input string name);
        $display("test %s finished, mismatches so far %0d", name, num_errors);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic ticks(input int n);
        count_tick = 1'b1;
        repeat (n) @(negedge mclk);
        count_tick = 1'b0;
    endtask

    // waits for one watchdog reset, then checks kept flag and cleared bits
    task automatic wait_rst(input int base);
        for (int k = 0; k < 2000 && n_rst == base; k++) @(negedge mclk);
        chk("reset pulses", base + 1, n_rst);
        cpu.rd(OFF_MODE, q, e);
        chk("mode after reset", 32'h4, q);
        cpu.wr(OFF_MODE, 32'h0);
        cpu.rd(OFF_MODE, q, e);
        chk("timeout cleared", 32'h0, q);
    endtask

    initial begin
        num_errors = 0;
        total_checks = 0;
        n_rst = 0;
        reset = 1'b1;
        count_tick = 1'b0;
        sleeping = 1'b0;
        repeat (5) @(negedge mclk);
        reset = 1'b0;
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) cpu.wr(ROWS[i].a, ROWS[i].d);
            cpu.rd(ROWS[i].a, q, e);
            chk("slverr", {31'h0, ROWS[i].err}, {31'h0, e});
            if (!ROWS[i].err) chk("rdata", ROWS[i].x, q);
        end
        test_end("register map");

        cpu.wr(OFF_MODE, 32'h1);
        cpu.rd(OFF_MODE, q, e);
        chk("mode pending", 32'h0, q);
        chk("clock lock", 32'h1, {31'h0, clk_src_lock});
        ticks(40);
        cpu.rd(OFF_COUNT, q, e);
        chk("stopped count", 32'hff, q);
        chk("stopped irq", 32'h0, {31'h0, irq});
        cpu.feed();
        ticks(8);
        cpu.rd(OFF_COUNT, q, e);
        chk("prescaled count", 32'hfd, q);
        cpu.rd(OFF_MODE, q, e);
        chk("mode running", 32'h1, q);
        cpu.feed();
        cpu.rd(OFF_COUNT, q, e);
        chk("reloaded count", 32'hff, q);
        sleeping = 1'b1;
        count_tick = 1'b1;
        for (int k = 0; k < 2000 && irq !== 1'b1; k++) @(negedge mclk);
        chk("wake", 32'h1, {31'h0, wake_req});
        cpu.rd(OFF_MODE, q, e);
        chk("warning set", 32'h9, q);
        cpu.wr(OFF_MODE, 32'h9);
        chk("irq cleared", 32'h0, {31'h0, irq});
        repeat (300) @(negedge mclk);
        cpu.rd(OFF_MODE, q, e);
        chk("timeout flagged", 32'h5, q);
        chk("no chip reset", 32'h0, n_rst);
        count_tick = 1'b0;
        sleeping = 1'b0;
        test_end("interrupt mode");

        reset = 1'b1;
        repeat (5) @(negedge mclk);
        reset = 1'b0;
        cpu.rd(OFF_MODE, q, e);
        chk("mode after ext reset", 32'h0, q);

        n0 = n_rst;
        cpu.wr(OFF_MODE, 32'h3);
        cpu.feed();
        cpu.wr(OFF_FEED, 32'haa);
        cpu.rd(OFF_RELOAD, q, e);
        wait_rst(n0);
        test_end("feed error");

        cpu.wr(OFF_WINDOW, 32'h80);
        n0 = n_rst;
        cpu.wr(OFF_MODE, 32'h3);
        cpu.feed();
        cpu.feed();
        wait_rst(n0);
        cpu.wr(OFF_WINDOW, 32'hffffff);
        test_end("early feed");

        n0 = n_rst;
        cpu.wr(OFF_MODE, 32'h13);
        cpu.feed();
        cpu.wr(OFF_RELOAD, 32'h200);
        wait_rst(n0);
        cpu.rd(OFF_RELOAD, q, e);
        chk("guarded reload", 32'hff, q);
        test_end("reload guard");

        cpu.wr(OFF_MODE, 32'h3);
        cpu.feed();
        cpu.wr(OFF_MODE, 32'h0);
        cpu.feed();
        cpu.rd(OFF_MODE, q, e);
        chk("set only", 32'h3, q);
        n0 = n_rst;
        count_tick = 1'b1;
        wait_rst(n0);
        count_tick = 1'b0;
        test_end("timeout reset");
        summarize();
    end

    initial begin
        #200000;
        num_errors++;
        $display("watchdog expired before the tests ended");
        summarize();
    end
endmodule // tb
